// ### verilog/lcd_pkg.sv
package lcd_pkg;
  // ****************************************
  // display ram geometry
  // ****************************************
  localparam int          RAM_WORDS = 24;
  localparam int          PTR_W     = 5;
  localparam int          SUB_W     = 3;
  localparam int          ROWS      = 4;

  // ****************************************
  // command byte fields
  // ****************************************
  localparam int          CONT_BIT     = 7;
  localparam int          LP_BIT       = 4;
  localparam int          EN_BIT       = 3;
  localparam int          BIAS_BIT     = 2;
  localparam int          ALT_BIT      = 2;
  localparam int          IN_BANK_BIT  = 1;
  localparam int          OUT_BANK_BIT = 0;
  localparam logic [1:0]  OP_MODE      = 2'h2;
  localparam logic [3:0]  OP_DEV       = 4'hC;
  localparam logic [3:0]  OP_BLINK     = 4'hE;
  localparam logic [4:0]  OP_BANK      = 5'h1E;

  // ****************************************
  // drive modes and reset values
  // ****************************************
  localparam logic [1:0]  MUX_STATIC = 2'h1;
  localparam logic [1:0]  MUX_1_2    = 2'h2;
  localparam logic [1:0]  MUX_1_3    = 2'h3;
  localparam logic [1:0]  MUX_1_4    = 2'h0;
  localparam logic [1:0]  MUX_RST    = MUX_1_4;
  localparam logic [1:0]  BLINK_OFF  = 2'h0;
  localparam logic [1:0]  BLINK_2HZ  = 2'h1;
  localparam logic [1:0]  BLINK_1HZ  = 2'h2;
  localparam logic [1:0]  BLINK_05HZ = 2'h3;

  // ****************************************
  // timing
  // ****************************************
  localparam int          CLK_KHZ            = 40000;
  localparam int          BLINK_2HZ_HALF_MS  = 250;
  localparam int          BLINK_2HZ_HALF_CYC = BLINK_2HZ_HALF_MS * CLK_KHZ;
  localparam int          PHASE_LEN_DEF      = 64;
  localparam int          PHASE_LEN_MIN      = 16;
  localparam int          FILL_BITS          = 8;

  typedef enum logic [2:0] {CMD_PTR, CMD_MODE, CMD_DEV, CMD_BANK, CMD_BLINK, CMD_NONE} cmd_t;

  function automatic cmd_t cmd_kind(input logic [7:0] b);
    if (!b[6]) begin
      return CMD_PTR;
    end else if (b[6:5] == OP_MODE) begin
      return CMD_MODE;
    end else if (b[6:3] == OP_DEV) begin
      return CMD_DEV;
    end else if (b[6:3] == OP_BLINK) begin
      return CMD_BLINK;
    end else if (b[6:2] == OP_BANK) begin
      return CMD_BANK;
    end
    return CMD_NONE;
  endfunction : cmd_kind

  // backplane rows used by a drive mode, minus one
  function automatic logic [1:0] last_row_of(input logic [1:0] mux);
    case (mux)
      MUX_STATIC: return 2'h0;
      MUX_1_2:    return 2'h1;
      MUX_1_3:    return 2'h2;
      default:    return 2'h3;
    endcase
  endfunction : last_row_of
endpackage : lcd_pkg

// ### verilog/ram_if.sv
`timescale 1ns/10ps
interface ram_if #(parameter int AW = 5);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [1:0]    wr_row;
  logic          wr_bit;
  logic          rd_en;
  logic [AW-1:0] rd_addr;
  logic [3:0]    rd_data;

  modport ctrl (output wr_en, wr_addr, wr_row, wr_bit, rd_en, rd_addr, input rd_data);
  modport mem  (input wr_en, wr_addr, wr_row, wr_bit, rd_en, rd_addr, output rd_data);
endinterface : ram_if

// ### verilog/disp_ram.sv
`timescale 1ns/10ps
module disp_ram #(
  parameter int DEPTH = lcd_pkg::RAM_WORDS
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  ram_if.mem        bus
);
  import lcd_pkg::*;

  logic [ROWS-1:0] mem [DEPTH];

  // bit-wide writes so one byte can spread over several words
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (bus.wr_en) begin
      mem[bus.wr_addr][bus.wr_row] <= bus.wr_bit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus.rd_data <= '0;
    end else if (bus.rd_en) begin
      bus.rd_data <= mem[bus.rd_addr];
    end
  end
endmodule : disp_ram

// ### verilog/lcd_display_controller_cascade.sv
// Operation
// R1: executes every decoded command and holds the resulting status fields
// R2: stores display data bytes into ram in the drive mode's filling order
// R3: up to 16 drivers, told apart by subaddress pins and slave address bit
// R4: cascaded drivers keep backplane phases aligned to share one backplane set
// R5: reset brings every driver to the same phase without the align line
// R6: align line is open-drain: only pulled low, pulled up otherwise
// R7: drive align line at last backplane phase, monitor it in other phases
// R8: on lost alignment, follow the first align assertion from any driver
// R9: bias flag 1 selects one-half bias, 0 the third bias
// R10: input bank bit steers incoming data to bits 0/0,1 or 2/2,3
// R11: output bank bit picks bits 0/0,1 or 2/2,3 for display
// R12: show flag 0 blanks the display, 1 shows ram contents
// R13: power save flag 0 normal, 1 power saving
// R14: pointer command loads a 5-bit index 0 to 23
// R15: device select loads a 3-bit value into the subaddress counter
// R16: blink rate 00 off, 01 2 Hz, 10 1 Hz, 11 0.5 Hz
// R17: flicker style 0 normal blink, 1 alternate between ram banks
// R18: drive mode 01 static, 10 1:2, 11 1:3, 00 1:4
// R19: top bit set means another command follows, clear means data follows
// R20: alternation blink and bank switching do nothing in 1:3 and 1:4
// R21: pointer and subaddress counter advance after stored display data
// R22: blanking and blink off phase leave ram contents untouched
`timescale 1ns/10ps
module lcd_display_controller_cascade #(
  parameter int BLINK_HALF_CYC = lcd_pkg::BLINK_2HZ_HALF_CYC,
  parameter int PHASE_LEN      = lcd_pkg::PHASE_LEN_DEF
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      link_clk_i,
  input  wire logic                      xfer_start_i,
  input  wire logic                      byte_valid_i,
  input  wire logic [7:0]                byte_i,
  output logic                           byte_ready_o,
  input  wire logic [lcd_pkg::SUB_W-1:0] chip_sub_select_pins_i,
  input  wire logic                      addr_low_bit_pin_i,
  input  wire logic                      align_in_i,
  output logic                           align_out_o,
  output logic                           align_oe_o,
  output logic [1:0]                     drive_mux_o,
  output logic                           half_bias_o,
  output logic                           show_output_on_o,
  output logic                           power_save_o,
  output logic [lcd_pkg::PTR_W-1:0]      ram_index_o,
  output logic [lcd_pkg::SUB_W-1:0]      sub_counter_o,
  output logic                           in_bank_o,
  output logic                           out_bank_o,
  output logic [1:0]                     blink_rate_o,
  output logic                           flicker_style_o,
  output logic                           slave_addr_lsb_o,
  output logic [1:0]                     bp_phase_o,
  output logic                           seg_valid_o,
  output logic [lcd_pkg::PTR_W-1:0]      seg_index_o,
  output logic                           seg_on_o
);
  import lcd_pkg::*;

  typedef enum logic {PH_CMD, PH_DATA} xfer_t;

  if (PHASE_LEN < PHASE_LEN_MIN || BLINK_HALF_CYC < 1) begin : g_chk
    $error("phase length too short for a ram scan, or blink count zero");
  end

  // ****************************************
  // pin synchronisers and ram
  // ****************************************
  logic [SUB_W-1:0] sub_s1;
  logic [SUB_W-1:0] sub_s2;
  logic             sa_s1;
  ram_if #(.AW(PTR_W)) ram ();

  disp_ram #(.DEPTH(RAM_WORDS)) u_ram (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .bus   (ram.mem)
  );

  // R3: subaddress and slave bit pins
  always_ff @(posedge clk_i) begin
    sub_s1           <= chip_sub_select_pins_i;
    sub_s2           <= sub_s1;
    sa_s1            <= addr_low_bit_pin_i;
    slave_addr_lsb_o <= sa_s1;
  end

  // ****************************************
  // command execution
  // ****************************************
  xfer_t      xfer;
  logic       accept;
  logic       small_mux;
  cmd_t       kind;
  logic [3:0] bits_left;
  logic [7:0] sh;
  logic [1:0] row;
  logic [1:0] last_row;

  assign accept    = byte_valid_i && byte_ready_o;
  assign kind      = cmd_kind(byte_i);
  assign small_mux = (drive_mux_o == MUX_STATIC) || (drive_mux_o == MUX_1_2);
  assign last_row  = last_row_of(drive_mux_o);

  // R19: continuation bit switches to data
  always_ff @(posedge clk_i) begin
    if (rst_i || xfer_start_i) begin
      xfer <= PH_CMD;
    end else if (accept && xfer == PH_CMD && !byte_i[CONT_BIT]) begin
      xfer <= PH_DATA;
    end
  end

  // R1: status fields from commands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_mux_o      <= MUX_RST;
      half_bias_o      <= 1'b0;
      show_output_on_o <= 1'b0;
      power_save_o     <= 1'b0;
      in_bank_o        <= 1'b0;
      out_bank_o       <= 1'b0;
      blink_rate_o     <= BLINK_OFF;
      flicker_style_o  <= 1'b0;
    end else if (accept && xfer == PH_CMD) begin
      case (kind)
        CMD_MODE: begin
          // R9 R12 R13 R18: mode fields
          power_save_o     <= byte_i[LP_BIT];
          show_output_on_o <= byte_i[EN_BIT];
          half_bias_o      <= byte_i[BIAS_BIT];
          drive_mux_o      <= byte_i[1:0];
        end
        CMD_BLINK: begin
          // R16 R17: blink fields
          blink_rate_o    <= byte_i[1:0];
          flicker_style_o <= byte_i[ALT_BIT];
        end
        CMD_BANK: begin
          // R20: bank select ignored in 1:3 and 1:4
          if (small_mux) begin
            in_bank_o  <= byte_i[IN_BANK_BIT];
            out_bank_o <= byte_i[OUT_BANK_BIT];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // data filling, one ram bit per cycle
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      byte_ready_o  <= 1'b1;
      bits_left     <= '0;
      sh            <= '0;
      row           <= '0;
      ram_index_o   <= '0;
      sub_counter_o <= '0;
    end else if (accept && xfer == PH_CMD) begin
      // R14: pointer load
      if (kind == CMD_PTR) begin
        ram_index_o <= byte_i[PTR_W-1:0];
        row         <= '0;
      end
      // R15: subaddress load
      if (kind == CMD_DEV) begin
        sub_counter_o <= byte_i[SUB_W-1:0];
      end
    end else if (accept) begin
      sh           <= byte_i;
      bits_left    <= 4'(FILL_BITS);
      byte_ready_o <= 1'b0;
    end else if (bits_left != '0) begin
      sh           <= {sh[6:0], 1'b0};
      bits_left    <= bits_left - 4'h1;
      byte_ready_o <= (bits_left == 4'h1);
      // R2: filling order follows rows of the mode
      if (row >= last_row) begin
        row <= '0;
        // R21: pointer wraps into next subaddress
        if (ram_index_o == PTR_W'(RAM_WORDS - 1)) begin
          ram_index_o   <= '0;
          sub_counter_o <= sub_counter_o + SUB_W'(1);
        end else begin
          ram_index_o <= ram_index_o + PTR_W'(1);
        end
      end else begin
        row <= row + 2'h1;
      end
    end
  end

  // R3: only the addressed driver stores data
  assign ram.wr_en   = (bits_left != '0) && (sub_counter_o == sub_s2);
  assign ram.wr_addr = ram_index_o;
  // R10: input bank moves static and 1:2 data to bits 2,3
  assign ram.wr_row  = row + ((small_mux && in_bank_o) ? 2'h2 : 2'h0);
  assign ram.wr_bit  = sh[7];

  // ****************************************
  // blink timing
  // ****************************************
  int         blink_cnt;
  logic [2:0] blink_div;
  logic       blink_ph;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blink_cnt <= 0;
      blink_div <= '0;
    end else if (blink_cnt >= BLINK_HALF_CYC - 1) begin
      blink_cnt <= 0;
      blink_div <= blink_div + 3'h1;
    end else begin
      blink_cnt <= blink_cnt + 1;
    end
  end

  // R16: rate selects divider tap
  always_comb begin
    case (blink_rate_o)
      BLINK_2HZ:  blink_ph = blink_div[0];
      BLINK_1HZ:  blink_ph = blink_div[1];
      BLINK_05HZ: blink_ph = blink_div[2];
      default:    blink_ph = 1'b0;
    endcase
  end

  // ****************************************
  // display scan in the system domain
  // ****************************************
  logic             tg_s1;
  logic             tg_s2;
  logic             tg_s3;
  logic             ph_tgl;
  logic [1:0]       scan_row;
  logic             scanning;
  logic [PTR_W-1:0] scan_addr;
  logic             rd_pend;
  logic [PTR_W-1:0] rd_idx;
  logic             bank_eff;
  logic             disp_on;
  logic [1:0]       out_row;

  // R17 R20: alternation only in static and 1:2
  assign bank_eff = out_bank_o ^ (flicker_style_o && small_mux && blink_ph);
  // R12 R22: blanking gates output only, ram is left alone
  assign disp_on  = show_output_on_o && !(blink_ph && !flicker_style_o);
  // R11: output bank picks bits 2,3
  assign out_row  = scan_row + ((small_mux && bank_eff) ? 2'h2 : 2'h0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tg_s1 <= 1'b0;
      tg_s2 <= 1'b0;
      tg_s3 <= 1'b0;
    end else begin
      tg_s1 <= ph_tgl;
      tg_s2 <= tg_s1;
      tg_s3 <= tg_s2;
    end
  end

  // phase value is held stable for a whole phase, so it is sampled on the toggle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scan_row  <= '0;
      scanning  <= 1'b0;
      scan_addr <= '0;
      rd_pend   <= 1'b0;
      rd_idx    <= '0;
    end else begin
      rd_pend <= scanning;
      rd_idx  <= scan_addr;
      if (tg_s2 != tg_s3) begin
        scan_row  <= bp_phase_o;
        scanning  <= 1'b1;
        scan_addr <= '0;
      end else if (scanning) begin
        scanning  <= (scan_addr != PTR_W'(RAM_WORDS - 1));
        scan_addr <= scan_addr + PTR_W'(1);
      end
    end
  end

  assign ram.rd_en   = scanning;
  assign ram.rd_addr = scan_addr;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seg_valid_o <= 1'b0;
      seg_index_o <= '0;
      seg_on_o    <= 1'b0;
    end else begin
      seg_valid_o <= rd_pend;
      seg_index_o <= rd_idx;
      seg_on_o    <= disp_on && ram.rd_data[out_row];
    end
  end

  // ****************************************
  // link domain: backplane phase and align line
  // ****************************************
  logic       lr_s1;
  logic       lr_s2;
  logic [1:0] mx_s1;
  logic [1:0] mx_s2;
  logic [1:0] mx_held;
  logic       al_s1;
  logic       al_s2;
  logic       al_s3;
  int         ph_cnt;
  logic [1:0] last_ph;
  logic       align_fall;

  assign last_ph    = last_row_of(mx_held);
  assign align_fall = al_s3 && !al_s2;

  always_ff @(posedge link_clk_i) begin
    lr_s1 <= rst_i;
    lr_s2 <= lr_s1;
    mx_s1 <= drive_mux_o;
    mx_s2 <= mx_s1;
    // mode bits taken only when two copies agree, so a skewed change never shows
    if (mx_s1 == mx_s2) begin
      mx_held <= mx_s2;
    end
    al_s1 <= align_in_i;
    al_s2 <= al_s1;
    al_s3 <= al_s2;
  end

  // R4 R5: every driver leaves reset at phase 0
  always_ff @(posedge link_clk_i) begin
    if (lr_s2) begin
      bp_phase_o <= '0;
      ph_cnt     <= 0;
      ph_tgl     <= 1'b0;
    end else if (align_fall && bp_phase_o != last_ph) begin
      // R8: follow the first align assertion
      bp_phase_o <= last_ph;
      ph_cnt     <= 0;
      ph_tgl     <= !ph_tgl;
    end else if (ph_cnt >= PHASE_LEN - 1) begin
      bp_phase_o <= (bp_phase_o >= last_ph) ? 2'h0 : bp_phase_o + 2'h1;
      ph_cnt     <= 0;
      ph_tgl     <= !ph_tgl;
    end else begin
      ph_cnt <= ph_cnt + 1;
    end
  end

  // R6 R7: pull low only during the last phase
  always_ff @(posedge link_clk_i) begin
    align_out_o <= 1'b0;
    align_oe_o  <= !lr_s2 && (bp_phase_o == last_ph);
  end

  // ****************************************
  // assertions
  // ****************************************
  a_mode_fields: assert property (@(posedge clk_i) disable iff (rst_i) // R18
    accept && xfer == PH_CMD && kind == CMD_MODE |=> drive_mux_o == $past(byte_i[1:0]))
    else $error("drive mode not taken from mode command");
  a_bias_flag: assert property (@(posedge clk_i) disable iff (rst_i) // R9
    accept && xfer == PH_CMD && kind == CMD_MODE |=> half_bias_o == $past(byte_i[BIAS_BIT]))
    else $error("bias flag not taken from mode command");
  a_power_flag: assert property (@(posedge clk_i) disable iff (rst_i) // R13
    accept && xfer == PH_CMD && kind == CMD_MODE |=> power_save_o == $past(byte_i[LP_BIT]))
    else $error("power save flag not taken");
  a_ptr_load: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    accept && xfer == PH_CMD && kind == CMD_PTR |=> ram_index_o == $past(byte_i[4:0]))
    else $error("pointer not loaded");
  a_sub_load: assert property (@(posedge clk_i) disable iff (rst_i) // R15
    accept && xfer == PH_CMD && kind == CMD_DEV |=> sub_counter_o == $past(byte_i[2:0]))
    else $error("subaddress counter not loaded");
  a_bank_frozen: assert property (@(posedge clk_i) disable iff (rst_i) // R20
    accept && xfer == PH_CMD && kind == CMD_BANK && !small_mux |=> $stable(in_bank_o) && $stable(out_bank_o))
    else $error("bank changed in 1:3 or 1:4 mode");
  a_data_phase: assert property (@(posedge clk_i) disable iff (rst_i || xfer_start_i) // R19
    accept && xfer == PH_CMD && !byte_i[CONT_BIT] |=> xfer == PH_DATA)
    else $error("last command byte did not open data phase");
  a_fill_time: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    accept && xfer == PH_DATA |=> !byte_ready_o [*8] ##1 byte_ready_o)
    else $error("byte fill did not take eight cycles");
  a_blank_out: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    rd_pend && !show_output_on_o |=> !seg_on_o)
    else $error("segment shown while blanked");
  a_align_drive: assert property (@(posedge link_clk_i) disable iff (lr_s2) // R7
    ##1 align_oe_o == $past(bp_phase_o == last_ph))
    else $error("align line not driven at last phase");
  a_realign: assert property (@(posedge link_clk_i) disable iff (lr_s2) // R8
    align_fall && bp_phase_o != last_ph |=> bp_phase_o == $past(last_ph) && ph_cnt == 0)
    else $error("phase did not follow align line");

  c_data_byte: cover property (@(posedge clk_i) disable iff (rst_i) accept && xfer == PH_DATA);
  c_sub_wrap: cover property (@(posedge clk_i) disable iff (rst_i) $changed(sub_counter_o) && bits_left != '0);
  c_realign: cover property (@(posedge link_clk_i) disable iff (lr_s2) align_fall && bp_phase_o != last_ph);
  c_alt_blink: cover property (@(posedge clk_i) disable iff (rst_i) seg_valid_o && bank_eff != out_bank_o);
endmodule : lcd_display_controller_cascade

// ### tb/lcd_cascade_peer.sv
`timescale 1ns/10ps
module lcd_cascade_peer #(
  parameter int PLEN = 16
) (
  input  wire logic       link_clk_i,
  input  wire logic       en_i,
  output logic            pull_o,
  output logic [1:0]      phase_o,
  output logic            mid_o
);
  logic [7:0] cnt;

  // ****************************************
  // free running 1:4 backplane phases
  // ****************************************
  always_ff @(posedge link_clk_i) begin
    if (!en_i) begin
      cnt     <= 8'h00;
      phase_o <= 2'h0;
    end else if (cnt == 8'(PLEN - 1)) begin
      cnt     <= 8'h00;
      phase_o <= phase_o + 2'h1;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  assign pull_o = en_i && (phase_o == 2'h3);
  assign mid_o  = (cnt == 8'(PLEN / 2));
endmodule : lcd_cascade_peer

// ### tb/lcd_display_controller_cascade_tb_top.sv
`timescale 1ns/10ps
module lcd_display_controller_cascade_tb_top;
  import lcd_pkg::*;
  localparam int PLEN = 16;
  logic        clk_i, rst_i, link_clk_i, xfer_start_i, byte_valid_i, addr_low_bit_pin_i, peer_en;
  logic [7:0]  byte_i;
  logic [2:0]  chip_sub_select_pins_i, sub_counter_o;
  logic        byte_ready_o, align_out_o, align_oe_o, half_bias_o, show_output_on_o, power_save_o;
  logic        in_bank_o, out_bank_o, flicker_style_o, slave_addr_lsb_o, seg_valid_o, seg_on_o;
  logic        peer_pull, peer_mid, align_line;
  logic [1:0]  drive_mux_o, blink_rate_o, bp_phase_o, peer_phase;
  logic [4:0]  ram_index_o, seg_index_o;
  logic [17:0] stat;
  logic        seg_seen [2][24];
  int          error_cnt = 0;
  int          tests_run = 0;
  int          n;
  logic [25:0] rows [19] = '{
    {8'hDD, 2'h1, 3'h7, 2'h0, 3'h0, 5'h00, 3'h0}, {8'hCA, 2'h2, 3'h2, 2'h0, 3'h0, 5'h00, 3'h0},
    {8'hFB, 2'h2, 3'h2, 2'h3, 3'h0, 5'h00, 3'h0}, {8'hF5, 2'h2, 3'h2, 2'h3, 3'h3, 5'h00, 3'h0},
    {8'hF2, 2'h2, 3'h2, 2'h3, 3'h4, 5'h00, 3'h0}, {8'hF3, 2'h2, 3'h2, 2'h3, 3'h6, 5'h00, 3'h0},
    {8'hF0, 2'h2, 3'h2, 2'h3, 3'h0, 5'h00, 3'h0}, {8'h97, 2'h2, 3'h2, 2'h3, 3'h0, 5'h17, 3'h0},
    {8'hE5, 2'h2, 3'h2, 2'h3, 3'h0, 5'h17, 3'h5}, {8'hCB, 2'h3, 3'h2, 2'h3, 3'h0, 5'h17, 3'h5},
    {8'hF8, 2'h3, 3'h2, 2'h3, 3'h0, 5'h17, 3'h5}, {8'hC8, 2'h0, 3'h2, 2'h3, 3'h0, 5'h17, 3'h5},
    {8'hF8, 2'h0, 3'h2, 2'h3, 3'h0, 5'h17, 3'h5}, {8'hFC, 2'h0, 3'h2, 2'h3, 3'h0, 5'h17, 3'h5},
    {8'hC1, 2'h1, 3'h0, 2'h3, 3'h0, 5'h17, 3'h5}, {8'hF8, 2'h1, 3'h0, 2'h0, 3'h0, 5'h17, 3'h5},
    {8'hF4, 2'h1, 3'h0, 2'h0, 3'h1, 5'h17, 3'h5}, {8'hF0, 2'h1, 3'h0, 2'h0, 3'h0, 5'h17, 3'h5},
    {8'h80, 2'h1, 3'h0, 2'h0, 3'h0, 5'h00, 3'h5}};

  assign stat = {drive_mux_o, half_bias_o, show_output_on_o, power_save_o, in_bank_o, out_bank_o,
                 blink_rate_o, flicker_style_o, ram_index_o, sub_counter_o};
  assign align_line = !(align_oe_o || peer_pull);

  lcd_display_controller_cascade #(.BLINK_HALF_CYC(20), .PHASE_LEN(PLEN)) dut_u (
    .clk_i, .rst_i, .link_clk_i, .xfer_start_i, .byte_valid_i, .byte_i, .byte_ready_o,
    .chip_sub_select_pins_i, .addr_low_bit_pin_i, .align_in_i(align_line), .align_out_o, .align_oe_o,
    .drive_mux_o, .half_bias_o, .show_output_on_o, .power_save_o, .ram_index_o, .sub_counter_o,
    .in_bank_o, .out_bank_o, .blink_rate_o, .flicker_style_o, .slave_addr_lsb_o, .bp_phase_o,
    .seg_valid_o, .seg_index_o, .seg_on_o);

  lcd_cascade_peer #(.PLEN(PLEN)) peer_u (
    .link_clk_i, .en_i(peer_en), .pull_o(peer_pull), .phase_o(peer_phase), .mid_o(peer_mid));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  initial begin
    link_clk_i = 1'b0;
    #5;
    forever begin
      link_clk_i = ~link_clk_i;
      #24;
    end
  end

  always @(posedge clk_i) begin
    if (seg_valid_o === 1'b1 && bp_phase_o < 2'h2 && seg_index_o < 5'h18) begin
      seg_seen[bp_phase_o[0]][seg_index_o] <= seg_on_o;
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic send_byte(input logic [7:0] b);
    @(posedge clk_i);
    byte_valid_i <= 1'b1;
    byte_i       <= b;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (byte_ready_o !== 1'b1 && n < 40);
    byte_valid_i <= 1'b0;
    if (byte_ready_o !== 1'b1) begin
      check("byte taken", byte_ready_o, 1);
      report_and_stop();
    end
  endtask : send_byte

  task automatic xfer(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, input logic [7:0] d);
    @(posedge clk_i);
    xfer_start_i <= 1'b1;
    @(posedge clk_i);
    xfer_start_i <= 1'b0;
    send_byte(a);
    if (a[7]) send_byte(b);
    if (a[7] && b[7]) send_byte(c);
    if (a[7] && b[7] && c[7]) send_byte(d);
  endtask : xfer

  task automatic wait_phase(input logic [1:0] p);
    n = 0;
    while (bp_phase_o !== p && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    if (bp_phase_o !== p) begin
      check("phase wait", bp_phase_o, p);
      report_and_stop();
    end
  endtask : wait_phase

  task automatic scan;
    seg_seen = '{default: 1'bx};
    repeat (200) @(posedge clk_i);
  endtask : scan

  task automatic seg_chk(input logic [4:0] idx, input logic e0, input logic e1);
    check("seg phase0", seg_seen[0][idx], e0);
    check("seg phase1", seg_seen[1][idx], e1);
  endtask : seg_chk

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst_i = 1'b1;
    xfer_start_i = 1'b0;
    byte_valid_i = 1'b0;
    byte_i = 8'h00;
    chip_sub_select_pins_i = 3'h5;
    addr_low_bit_pin_i = 1'b1;
    peer_en = 1'b0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check("status reset", stat, 0);
    check("ready reset", byte_ready_o, 1);
    check("phase reset", bp_phase_o, 0);
    $display("test reset done");
    wait_phase(2'h3);
    repeat (3) @(posedge link_clk_i);
    #1;
    check("align oe", align_oe_o, 1);
    check("align line", align_line, 0);
    check("align out", align_out_o, 0);
    wait_phase(2'h0);
    repeat (3) @(posedge link_clk_i);
    #1;
    check("align idle", align_oe_o, 0);
    check("line idle", align_line, 1);
    wait_phase(2'h1);
    // peer starts nine link clocks late so its pull falls in our phase 0
    repeat (9) @(posedge link_clk_i);
    peer_en <= 1'b1;
    repeat (150) @(posedge link_clk_i);
    n = 0;
    while (peer_mid !== 1'b1 && n < 40) begin
      @(posedge link_clk_i);
      n++;
    end
    #1;
    check("phase realigned", bp_phase_o, peer_phase);
    peer_en <= 1'b0;
    $display("test align done");
    xfer(8'hFF, 8'hFF, 8'hFF, 8'hFF);
    foreach (rows[i]) begin
      send_byte(rows[i][25:18]);
      @(posedge clk_i);
      #1;
      check("status row", stat, rows[i][17:0]);
    end
    $display("test command table done");
    xfer(8'hCA, 8'hF8, 8'hE5, 8'h16);
    send_byte(8'hB4);
    @(posedge clk_i);
    #1;
    check("ready after data", byte_ready_o, 0);
    n = 0;
    while (byte_ready_o !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check("ready gap", n, 7);
    check("pointer advance", ram_index_o, 2);
    check("sub advance", sub_counter_o, 6);
    scan();
    seg_chk(5'h16, 1'b1, 1'b0);
    seg_chk(5'h17, 1'b1, 1'b1);
    seg_chk(5'h00, 1'b0, 1'b0);
    xfer(8'h42, 8'h00, 8'h00, 8'h00);
    scan();
    seg_chk(5'h16, 1'b0, 1'b0);
    xfer(8'h4A, 8'h00, 8'h00, 8'h00);
    scan();
    seg_chk(5'h16, 1'b1, 1'b0);
    xfer(8'hFB, 8'hE5, 8'h16, 8'h00);
    send_byte(8'h40);
    scan();
    seg_chk(5'h16, 1'b0, 1'b1);
    seg_chk(5'h17, 1'b0, 1'b0);
    xfer(8'h7A, 8'h00, 8'h00, 8'h00);
    scan();
    seg_chk(5'h16, 1'b1, 1'b0);
    $display("test display data done");
    check("addr bit high", slave_addr_lsb_o, 1);
    addr_low_bit_pin_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    check("addr bit low", slave_addr_lsb_o, 0);
    $display("test address bit done");
    report_and_stop();
  end
endmodule : lcd_display_controller_cascade_tb_top
